// ===== dpra_far.sv
// Far-side model: system bus master and exchange responder.
// Assumes the bench raises go_i and drops it after done_o.
`timescale 1ns/100ps
module dpra_far
  import dpra_pkg::*;
#(
  parameter int ACK_DLY = 3
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        ext_req_i,
  input  wire logic        xack_i,
  output dpra_sys_t        sys_o,
  output logic             ext_ack_o,
  output logic             done_o
);
  logic [3:0] cnt_q;

  // Master holds its command until acknowledged; released address churns
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sys_o  <= SYS_RST;
      done_o <= 1'b0;
    end else if (go_i && !done_o && !xack_i) begin
      sys_o <= '{rd_n: wr_i, wr_n: !wr_i, addr: addr_i};
    end else begin
      sys_o  <= '{rd_n: 1'b1, wr_n: 1'b1, addr: ~sys_o.addr};
      done_o <= go_i && (done_o || xack_i);
    end
  end

  // Exchange acknowledge after a delay, held until the request drops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !ext_req_i) begin
      cnt_q     <= 4'h0;
      ext_ack_o <= 1'b0;
    end else if (cnt_q != 4'(ACK_DLY)) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      ext_ack_o <= 1'b1;
    end
  end
endmodule : dpra_far

// ===== dpra_pkg.sv
// Constants, state codes and carrier types for the dual-port RAM arbiter.
// Assumes a single 20 MHz board clock and a synchronous active-low reset.
// Behaviour
// - Shared bus always in one of three states
// - Idle means local side owns, not using
// - Local RAM request moves idle to local-busy
// - Local completion returns control to local-idle
// - System request moves idle to system-busy
// - System access lasts 150 ns minimum
// - Local off-board access leaves shared bus idle
// - Off-board transfer adds 200 ns overhead
// - Pure local activity needs no outer bus
// - DRAM controller: idle, write, read, refresh
// - Idle controller watches requests, counts toward refresh
// - Refresh requested and generated internally
// - Row strobe, column strobe, 8-bit multiplexed address
// - Window decode forms high RAM address bits
// - Window hit only for in-window system addresses
// - Every local on-board access gets wait states
// - RAM select with memory command starts arbitration
// - Slave mode only without local access
// - Local gate passes local command during access
package dpra_pkg;

  localparam int CLK_NS         = 50;
  localparam int SYS_MIN_NS     = 150;
  localparam int SYS_MIN_CYC    = (SYS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFFBUS_OVH_NS  = 200;
  localparam int OFFBUS_OVH_CYC = (OFFBUS_OVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOC_WAIT_NS    = 50;
  localparam int LOC_WAIT_CYC   = (LOC_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRAM_CYCLE_NS  = 200;
  localparam int DRAM_CYCLE_CYC = (DRAM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_NS     = 15000;
  localparam int REFRESH_CYC    = REFRESH_NS / CLK_NS;

  localparam logic [2:0] SYS_LAST     = 3'(SYS_MIN_CYC - 1);
  localparam logic [2:0] OVH_LAST     = 3'(OFFBUS_OVH_CYC - 1);
  localparam logic [2:0] WAIT_LAST    = 3'(LOC_WAIT_CYC - 1);
  localparam logic [2:0] DRAM_LAST    = 3'(DRAM_CYCLE_CYC - 1);
  localparam logic [2:0] CAS_PHASE    = 3'h1;
  localparam logic [8:0] REFRESH_LAST = 9'(REFRESH_CYC - 1);

  // Window decode: 16K-word blocks, RAM block bits above bit 13
  localparam int BLK_LSB = 14;

  typedef enum logic [2:0] {
    ARB_LOC_IDLE = 3'b001,
    ARB_LOC_BUSY = 3'b010,
    ARB_SYS_BUSY = 3'b100
  } dpra_arb_t;

  typedef enum logic [3:0] {
    DR_IDLE    = 4'b0001,
    DR_WRITE   = 4'b0010,
    DR_READ    = 4'b0100,
    DR_REFRESH = 4'b1000
  } dpra_dram_t;

  typedef struct packed {
    logic        mem_cmd;
    logic        ram_access;
    logic        offbus;
    logic        wr;
    logic [15:0] addr;
  } dpra_loc_t;

  typedef struct packed {
    logic        rd_n;
    logic        wr_n;
    logic [19:0] addr;
  } dpra_sys_t;

  typedef struct packed {
    logic [5:0] base;
    logic [1:0] size;
  } dpra_cfg_t;

  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [7:0] addr;
  } dpra_dram_bus_t;

  localparam dpra_sys_t      SYS_RST  = '{rd_n: 1'b1, wr_n: 1'b1, addr: 20'h00000};
  localparam dpra_cfg_t      CFG_RST  = '{base: 6'h00, size: 2'h0};
  localparam dpra_dram_bus_t DRAM_RST = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: 8'h00};

endpackage : dpra_pkg

// ===== dpra_top.sv
// Dual-port DRAM arbiter: ownership machine, window decode, DRAM strobes.
// Local bus runs on clk_i; system bus, straps and exchange ack are pins.
`timescale 1ns/100ps
module dpra_top
  import dpra_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire dpra_loc_t      loc_i,
  output logic                loc_ready_o,
  output logic                ext_req_o,
  input  wire logic           ext_ack_i,
  input  wire dpra_sys_t      sys_i,
  input  wire dpra_cfg_t      cfg_i,
  output logic                sys_xack_o,
  output logic                window_hit_request_o,
  output logic                shared_ram_select_n_o,
  output logic                local_command_gate_n_o,
  output logic                slave_cmd_gate_n_o,
  output dpra_dram_bus_t      dram_o,
  output dpra_arb_t           arb_state_o,
  output dpra_dram_t          dram_state_o
);

  // Two-stage synchronisers for everything arriving from pins
  dpra_sys_t      sys_s1_q;
  dpra_sys_t      sys_s2_q;
  dpra_cfg_t      cfg_s1_q;
  dpra_cfg_t      cfg_s2_q;
  logic           ack_s1_q;
  logic           ack_s2_q;

  dpra_arb_t      arb_q;
  dpra_arb_t      arb_d;
  dpra_dram_t     dr_q;
  dpra_dram_t     dr_d;

  logic [2:0]     phase_q;
  logic [8:0]     ref_cnt_q;
  logic           ref_pend_q;
  logic [7:0]     ref_row_q;
  logic [15:0]    cyc_addr_q;
  logic           acc_started_q;
  logic           dram_done_q;
  logic [2:0]     sys_cnt_q;
  logic [2:0]     loc_cnt_q;
  logic           loc_done_q;
  logic           loc_ready_q;
  logic           ext_req_q;
  logic           sys_xack_q;
  logic           hit_q;
  logic           sel_n_q;
  logic           lgate_n_q;
  logic           sgate_n_q;
  dpra_dram_bus_t dram_q;

  logic [5:0]     blk_diff;
  logic           in_window;
  logic           sys_cmd;
  logic           sys_hit;
  logic [15:0]    win_addr;
  logic           loc_act;
  logic           loc_ram_req;
  logic           loc_off_req;
  logic           loc_on_req;
  logic           acc_req;
  logic           acc_wr;
  logic [15:0]    acc_addr;
  logic           loc_ready_set;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sys_s1_q <= SYS_RST;
      sys_s2_q <= SYS_RST;
      cfg_s1_q <= CFG_RST;
      cfg_s2_q <= CFG_RST;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      sys_s1_q <= sys_i;
      sys_s2_q <= sys_s1_q;
      cfg_s1_q <= cfg_i;
      cfg_s2_q <= cfg_s1_q;
      ack_s1_q <= ext_ack_i;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Window decode: block offset from the strapped base selects RAM block
  always_comb begin
    blk_diff  = sys_s2_q.addr[19:BLK_LSB] - cfg_s2_q.base;
    in_window = blk_diff <= {4'h0, cfg_s2_q.size};
    sys_cmd   = !sys_s2_q.rd_n || !sys_s2_q.wr_n;
    sys_hit   = sys_cmd && in_window;
    win_addr  = {blk_diff[1:0], sys_s2_q.addr[BLK_LSB-1:0]};
  end

  // Local request classification
  always_comb begin
    loc_act     = loc_i.mem_cmd && !loc_done_q;
    loc_ram_req = loc_act && loc_i.ram_access;
    loc_off_req = loc_act && !loc_i.ram_access && loc_i.offbus;
    loc_on_req  = loc_act && !loc_i.ram_access && !loc_i.offbus;
  end

  // Ownership machine
  always_comb begin
    arb_d = arb_q;
    unique case (arb_q)
      ARB_LOC_IDLE: begin
        if (loc_ram_req) begin
          arb_d = ARB_LOC_BUSY;
        end else if (sys_hit) begin
          arb_d = ARB_SYS_BUSY;
        end
      end
      ARB_LOC_BUSY: begin
        if (dram_done_q) begin
          arb_d = ARB_LOC_IDLE;
        end
      end
      ARB_SYS_BUSY: begin
        if (sys_xack_q && sys_cnt_q == SYS_LAST && !sys_cmd) begin
          arb_d = ARB_LOC_IDLE;
        end
      end
      default: begin
        arb_d = ARB_LOC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      arb_q <= ARB_LOC_IDLE;
    end else begin
      arb_q <= arb_d;
    end
  end

  // Minimum occupancy count for a system-bus owner
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sys_cnt_q <= 3'h0;
    end else if (arb_q != ARB_SYS_BUSY) begin
      sys_cnt_q <= 3'h0;
    end else if (sys_cnt_q != SYS_LAST) begin
      sys_cnt_q <= sys_cnt_q + 3'h1;
    end
  end

  // One DRAM cycle per ownership; started flag blocks a second issue
  always_comb begin
    acc_req  = (arb_q != ARB_LOC_IDLE) && !acc_started_q;
    acc_wr   = (arb_q == ARB_SYS_BUSY) ? !sys_s2_q.wr_n : loc_i.wr;
    acc_addr = (arb_q == ARB_SYS_BUSY) ? win_addr : loc_i.addr;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_started_q <= 1'b0;
    end else if (arb_d == ARB_LOC_IDLE) begin
      acc_started_q <= 1'b0;
    end else if (acc_req && dr_q == DR_IDLE && !ref_pend_q) begin
      acc_started_q <= 1'b1;
    end
  end

  // System exchange acknowledge held until the master drops its command
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sys_xack_q <= 1'b0;
    end else if (arb_q != ARB_SYS_BUSY) begin
      sys_xack_q <= 1'b0;
    end else if (dram_done_q) begin
      sys_xack_q <= 1'b1;
    end
  end

  // Refresh timer runs in every state; pending set wins over its clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ref_cnt_q  <= 9'h000;
      ref_pend_q <= 1'b0;
    end else begin
      ref_cnt_q <= (ref_cnt_q == REFRESH_LAST) ? 9'h000 : ref_cnt_q + 9'h001;
      if (ref_cnt_q == REFRESH_LAST) begin
        ref_pend_q <= 1'b1;
      end else if (dr_q == DR_IDLE && dr_d == DR_REFRESH) begin
        ref_pend_q <= 1'b0;
      end
    end
  end

  // DRAM controller state
  always_comb begin
    dr_d = dr_q;
    unique case (dr_q)
      DR_IDLE: begin
        if (ref_pend_q) begin
          dr_d = DR_REFRESH;
        end else if (acc_req) begin
          dr_d = acc_wr ? DR_WRITE : DR_READ;
        end
      end
      DR_WRITE, DR_READ, DR_REFRESH: begin
        if (phase_q == DRAM_LAST) begin
          dr_d = DR_IDLE;
        end
      end
      default: begin
        dr_d = DR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dr_q <= DR_IDLE;
    end else begin
      dr_q <= dr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase_q <= 3'h0;
    end else if (dr_q == DR_IDLE || phase_q == DRAM_LAST) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end

  // Cycle address latched at start; refresh row advances per refresh
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cyc_addr_q <= 16'h0000;
      ref_row_q  <= 8'h00;
    end else begin
      if (dr_q == DR_IDLE && (dr_d == DR_WRITE || dr_d == DR_READ)) begin
        cyc_addr_q <= acc_addr;
      end
      if (dr_q == DR_REFRESH && phase_q == DRAM_LAST) begin
        ref_row_q <= ref_row_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dram_done_q <= 1'b0;
    end else begin
      dram_done_q <= (dr_q == DR_WRITE || dr_q == DR_READ) && phase_q == DRAM_LAST;
    end
  end

  // Strobes: row first, column from CAS_PHASE, both released in last phase
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dram_q <= DRAM_RST;
    end else begin
      dram_q.ras_n <= (dr_q == DR_IDLE) || phase_q == DRAM_LAST;
      dram_q.cas_n <= !((dr_q == DR_WRITE || dr_q == DR_READ) &&
                        phase_q >= CAS_PHASE && phase_q != DRAM_LAST);
      dram_q.we_n  <= (dr_q != DR_WRITE);
      if (dr_q == DR_REFRESH) begin
        dram_q.addr <= ref_row_q;
      end else if (phase_q >= CAS_PHASE) begin
        dram_q.addr <= cyc_addr_q[7:0];
      end else begin
        dram_q.addr <= cyc_addr_q[15:8];
      end
    end
  end

  // Local wait-state and off-board overhead counter
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      loc_cnt_q <= 3'h0;
    end else if (!(loc_on_req || loc_off_req)) begin
      loc_cnt_q <= 3'h0;
    end else if (loc_cnt_q != 3'h7) begin
      loc_cnt_q <= loc_cnt_q + 3'h1;
    end
  end

  // Off-board request raised only after the overhead, shared bus untouched
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ext_req_q <= 1'b0;
    end else if (!loc_off_req || loc_ready_set) begin
      ext_req_q <= 1'b0;
    end else if (loc_cnt_q >= OVH_LAST) begin
      ext_req_q <= 1'b1;
    end
  end

  always_comb begin
    loc_ready_set = (arb_q == ARB_LOC_BUSY && dram_done_q) ||
                    (loc_on_req && loc_cnt_q > WAIT_LAST) ||
                    (loc_off_req && ext_req_q && ack_s2_q);
  end

  // One ready pulse per command; a new one needs the command to drop
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      loc_ready_q <= 1'b0;
      loc_done_q  <= 1'b0;
    end else begin
      loc_ready_q <= loc_ready_set;
      if (loc_ready_set) begin
        loc_done_q <= 1'b1;
      end else if (!loc_i.mem_cmd) begin
        loc_done_q <= 1'b0;
      end
    end
  end

  // Registered gates follow the next ownership state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hit_q     <= 1'b0;
      sel_n_q   <= 1'b1;
      lgate_n_q <= 1'b1;
      sgate_n_q <= 1'b1;
    end else begin
      hit_q     <= sys_hit;
      sel_n_q   <= (arb_d == ARB_LOC_IDLE);
      lgate_n_q <= (arb_d != ARB_LOC_BUSY);
      sgate_n_q <= (arb_d != ARB_SYS_BUSY);
    end
  end

  assign loc_ready_o            = loc_ready_q;
  assign ext_req_o              = ext_req_q;
  assign sys_xack_o             = sys_xack_q;
  assign window_hit_request_o   = hit_q;
  assign shared_ram_select_n_o  = sel_n_q;
  assign local_command_gate_n_o = lgate_n_q;
  assign slave_cmd_gate_n_o     = sgate_n_q;
  assign dram_o                 = dram_q;
  assign arb_state_o            = arb_q;
  assign dram_state_o           = dr_q;

endmodule : dpra_top

// ===== dpra_top_asserts.sv
// Port checker for the dual-port RAM arbiter.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module dpra_chk
  import dpra_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           rst_b_i,
  input wire dpra_loc_t      loc_i,
  input wire logic           loc_ready_o,
  input wire logic           ext_req_o,
  input wire logic           local_command_gate_n_o,
  input wire logic           slave_cmd_gate_n_o,
  input wire logic           shared_ram_select_n_o,
  input wire dpra_dram_bus_t dram_o,
  input wire dpra_arb_t      arb_state_o,
  input wire dpra_dram_t     dram_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [9:0] gap_q;

  // Cycles since the last refresh
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || dram_state_o == DR_REFRESH) gap_q <= 10'h000;
    else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
  end

  a_arb_one_hot: assert property ($onehot(arb_state_o))
    else $error("ownership state not one-hot");
  a_dram_one_hot: assert property ($onehot(dram_state_o))
    else $error("controller state not one-hot");
  a_busy_via_idle: assert property (arb_state_o == ARB_LOC_BUSY |=> arb_state_o != ARB_SYS_BUSY)
    else $error("system took bus straight from local");
  a_sys_min_own: assert property ($rose(arb_state_o == ARB_SYS_BUSY) |-> (arb_state_o == ARB_SYS_BUSY)[*3])
    else $error("system ownership under three cycles");
  a_local_gate: assert property (arb_state_o == ARB_LOC_BUSY |-> !local_command_gate_n_o && !shared_ram_select_n_o)
    else $error("local gate closed while local busy");
  a_slave_gate: assert property (arb_state_o == ARB_SYS_BUSY |-> !slave_cmd_gate_n_o && !shared_ram_select_n_o)
    else $error("slave gate closed while system busy");
  a_offbus_idle: assert property (ext_req_o |-> arb_state_o == ARB_LOC_IDLE)
    else $error("exchange left shared bus busy");
  a_offbus_ovh: assert property ($rose(ext_req_o) |-> $past(loc_i.mem_cmd, 4) && $past(loc_i.offbus, 4))
    else $error("exchange request too early");
  a_ready_wait: assert property ($rose(loc_i.mem_cmd) |-> !loc_ready_o ##1 !loc_ready_o)
    else $error("local access without wait state");
  a_cas_after_ras: assert property ($fell(dram_o.cas_n) |-> !dram_o.ras_n && !$past(dram_o.ras_n))
    else $error("column strobe without row strobe");
  a_ras_in_cycle: assert property (!dram_o.ras_n |-> dram_state_o != DR_IDLE)
    else $error("row strobe in idle");
  a_refresh_gap: assert property (gap_q < 10'h140)
    else $error("refresh overdue");

  c_sys_own: cover property (arb_state_o == ARB_SYS_BUSY);
  c_refresh: cover property (dram_state_o == DR_REFRESH);
  c_exchange: cover property ($rose(ext_req_o));
endmodule : dpra_chk

bind dpra_top dpra_chk dpra_chk_i (
  .clk_i                  (clk_i),
  .rst_b_i                (rst_b_i),
  .loc_i                  (loc_i),
  .loc_ready_o            (loc_ready_o),
  .ext_req_o              (ext_req_o),
  .local_command_gate_n_o (local_command_gate_n_o),
  .slave_cmd_gate_n_o     (slave_cmd_gate_n_o),
  .shared_ram_select_n_o  (shared_ram_select_n_o),
  .dram_o                 (dram_o),
  .arb_state_o            (arb_state_o),
  .dram_state_o           (dram_state_o)
);

// ===== dpra_top_tb_top.sv
// Self-checking bench for the dual-port RAM arbiter.
// Assumes dpra_top, the far-side model and the bound checker.
`timescale 1ns/100ps
module dpra_top_tb_top;
  import dpra_pkg::*;
  localparam dpra_cfg_t CFG = '{base: 6'h02, size: 2'h1};
  logic           clk_i   = 1'b0;
  logic           rst_b_i = 1'b0;
  logic           go, wr, fdone, ext_ack_i, loc_ready_o, ext_req_o, sys_xack_o;
  logic           window_hit_request_o, shared_ram_select_n_o;
  logic           local_command_gate_n_o, slave_cmd_gate_n_o;
  logic [19:0]    sa;
  dpra_loc_t      loc_i;
  dpra_sys_t      sys_i;
  dpra_cfg_t      cfg_i;
  dpra_dram_bus_t dram_o;
  dpra_arb_t      arb_state_o;
  dpra_dram_t     dram_state_o;
  int             err_count = 0;
  int             check_count = 0;
  int             cyc = 0;

  dpra_top dpra_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .loc_i(loc_i), .loc_ready_o(loc_ready_o),
    .ext_req_o(ext_req_o), .ext_ack_i(ext_ack_i), .sys_i(sys_i), .cfg_i(cfg_i), .sys_xack_o(sys_xack_o),
    .window_hit_request_o(window_hit_request_o), .shared_ram_select_n_o(shared_ram_select_n_o),
    .local_command_gate_n_o(local_command_gate_n_o), .slave_cmd_gate_n_o(slave_cmd_gate_n_o),
    .dram_o(dram_o), .arb_state_o(arb_state_o), .dram_state_o(dram_state_o));
  dpra_far dpra_far_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .wr_i(wr), .addr_i(sa),
    .ext_req_i(ext_req_o), .xack_i(sys_xack_o), .sys_o(sys_i), .ext_ack_o(ext_ack_i), .done_o(fdone));

  always #25 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic t_loc_ram(input logic w, input logic [15:0] a);
    int n;
    logic busy, we;
    logic [7:0] row, col;
    busy = 1'b0; we = 'x; row = 'x; col = 'x;
    loc_i = '{mem_cmd: 1'b1, ram_access: 1'b1, offbus: 1'b0, wr: w, addr: a};
    for (n = 0; n < 40 && loc_ready_o !== 1'b1; n++) begin
      tick(1);
      busy |= (arb_state_o === ARB_LOC_BUSY) && (local_command_gate_n_o === 1'b0);
      if (dram_state_o === (w ? DR_WRITE : DR_READ)) begin
        if (dram_o.ras_n === 1'b0 && dram_o.cas_n === 1'b1) row = dram_o.addr;
        if (dram_o.cas_n === 1'b0) begin
          col = dram_o.addr;
          we = dram_o.we_n;
        end
      end
    end
    chk_rng("local latency", 7, 15, n);
    chk_val("local busy", 1, busy);
    chk_val("row addr", a[15:8], row);
    chk_val("col addr", a[7:0], col);
    chk_val("write strobe", !w, we);
    loc_i.mem_cmd = 1'b0;
    tick(1);
    chk_val("arb idle", ARB_LOC_IDLE, arb_state_o);
  endtask : t_loc_ram

  task automatic t_outside(input logic off);
    int n, nq;
    logic calm;
    calm = 1'b1; nq = 0;
    loc_i = '{mem_cmd: 1'b1, ram_access: 1'b0, offbus: off, wr: 1'b1, addr: 16'h1234};
    for (n = 0; n < 40 && loc_ready_o !== 1'b1; n++) begin
      tick(1);
      calm &= (arb_state_o === ARB_LOC_IDLE) && (shared_ram_select_n_o === 1'b1);
      if (nq == 0 && ext_req_o === 1'b1) nq = n + 1;
    end
    chk_val("local done", 1, loc_ready_o);
    chk_val("shared bus idle", 1, calm);
    if (off) chk_rng("exchange overhead", 4, 6, nq);
    else chk_rng("wait states", 2, 3, n);
    loc_i.mem_cmd = 1'b0;
    tick(1);
  endtask : t_outside

  task automatic t_sys(input logic [19:0] a, input logic w, input logic in_win);
    int n, own;
    logic hit, gate;
    logic [15:0] ra;
    logic [7:0] row;
    hit = 1'b0; gate = 1'b0; own = 0; row = 'x;
    ra = {2'(a[19:14] - CFG.base), a[13:0]};
    sa = a; wr = w; go = 1'b1;
    for (n = 0; n < 30 && fdone !== 1'b1; n++) begin
      tick(1);
      hit |= window_hit_request_o === 1'b1;
      gate |= (slave_cmd_gate_n_o === 1'b0) && (shared_ram_select_n_o === 1'b0);
      own += (arb_state_o === ARB_SYS_BUSY);
      if (dram_state_o === (w ? DR_WRITE : DR_READ) && dram_o.ras_n === 1'b0 && dram_o.cas_n === 1'b1)
        row = dram_o.addr;
    end
    go = 1'b0;
    chk_val("system done", in_win, fdone);
    chk_val("window hit", in_win, hit);
    chk_val("slave gates", in_win, gate);
    if (in_win) chk_val("window row", ra[15:8], row);
    if (in_win) chk_rng("system ownership", 3, 30, own);
    tick(8);
    chk_val("arb back", ARB_LOC_IDLE, arb_state_o);
  endtask : t_sys

  task automatic t_both;
    int n;
    dpra_arb_t first;
    first = ARB_LOC_IDLE;
    sa = 20'h0c123; wr = 1'b1; go = 1'b1;
    loc_i = '{mem_cmd: 1'b1, ram_access: 1'b1, offbus: 1'b0, wr: 1'b0, addr: 16'h0042};
    for (n = 0; n < 40 && fdone !== 1'b1; n++) begin
      tick(1);
      if (first === ARB_LOC_IDLE) first = arb_state_o;
      if (loc_ready_o === 1'b1) loc_i.mem_cmd = 1'b0;
    end
    go = 1'b0;
    chk_val("first owner", ARB_LOC_BUSY, first);
    chk_val("system served", 1, fdone);
    tick(8);
  endtask : t_both

  task automatic t_refresh;
    int n, k;
    logic [7:0] r0;
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 400 && dram_state_o !== DR_REFRESH; n++) tick(1);
      chk_val("refresh seen", DR_REFRESH, dram_state_o);
      tick(1);
      chk_val("refresh strobes", 2'b01, {dram_o.ras_n, dram_o.cas_n});
      if (k == 1) chk_val("refresh row", 8'(r0 + 8'h01), dram_o.addr);
      r0 = dram_o.addr;
      tick(4);
    end
  endtask : t_refresh

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict;
    end
  end

  initial begin
    loc_i = '0; go = 1'b0; wr = 1'b0; sa = 20'h00000; cfg_i = CFG;
    tick(20);
    chk_val("reset arb", ARB_LOC_IDLE, arb_state_o);
    chk_val("reset dram", DR_IDLE, dram_state_o);
    chk_val("reset gates", 3'b111, {shared_ram_select_n_o, local_command_gate_n_o, slave_cmd_gate_n_o});
    rst_b_i = 1'b1;
    tick(2);
    t_loc_ram(1'b1, 16'ha55a);
    t_loc_ram(1'b0, 16'h5aa5);
    t_outside(1'b0);
    t_outside(1'b1);
    t_sys(20'h08abc, 1'b0, 1'b1);
    t_sys(20'h0fffe, 1'b1, 1'b1);
    t_sys(20'h10000, 1'b0, 1'b0);
    t_sys(20'h04000, 1'b1, 1'b0);
    t_both;
    t_refresh;
    print_verdict;
  end
endmodule : dpra_top_tb_top
